// ---- nvac_pkg.sv ----
/*
  nvac_pkg: constants for the data eeprom access controller.
  assumes a cpu special-function bus with byte-wide registers.
*/
package nvac_pkg;
  // sfr addresses of the cpu-side register window
  localparam logic [7:0] ADDR_NV_ADDRESS   = 8'h00;
  localparam logic [7:0] ADDR_NV_DATA      = 8'h01;
  localparam logic [7:0] ADDR_PTR_LOW      = 8'h02;
  localparam logic [7:0] ADDR_PTR_HIGH     = 8'h03;
  localparam logic [7:0] ADDR_INDIRECT     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CTRL     = 8'h05;
  // control register location behind the pointer
  localparam logic [7:0] CTRL_PTR_LOW      = 8'h40;
  localparam logic [7:0] CTRL_PTR_HIGH     = 8'h01;
  // control register field positions
  localparam int         BIT_WRITE_ENABLE  = 3;
  localparam int         BIT_WRITE_START   = 2;
  localparam int         BIT_READ_ENABLE   = 1;
  localparam int         BIT_READ_START    = 0;
  // irq control register field positions
  localparam int         BIT_IRQ_FLAG      = 0;
  localparam int         BIT_IRQ_ENABLE    = 1;
  localparam int         BIT_MF_FLAG       = 2;
  localparam int         BIT_MF_ENABLE     = 3;
  localparam int         BIT_GLOBAL_ENABLE = 4;
  // reset values
  localparam logic [7:0] RST_BYTE          = 8'h00;
  // timing
  localparam int         READ_CYCLES       = 2;
  localparam int         WRITE_TIME_US     = 2000;
  localparam int         CLK_MHZ           = 40;
  localparam int         WRITE_CYCLES      = WRITE_TIME_US * CLK_MHZ;
  // write timer tick divider, stands in for the asynchronous timer
  localparam int         TICK_DIV          = 40;
endpackage : nvac_pkg

// ---- nvac_ctrl.sv ----
/*
  nvac_ctrl: data eeprom access controller with a 32x8 storage array.
  assumes a cpu sfr port: address, write data, write and read strobes,
  read data one cycle after the read strobe; the cpu never waits.
*/
// The register offsets and the strobed register port are this design's own decisions.
// Operation
// - read starts only if read enable set; reads at nv_address_reg.
// - read end clears read start bit and loads nv_data_reg.
// - nv_data_reg holds until next read or write.
// - write start without write enable has no effect.
// - write length set by a timer independent of cpu clock; here a count of WRITE_CYCLES clk cycles, ended on a clk-divided tick.
// - write end clears write start bit.
// - write enable cleared at power-on.
// - pointer high resets to zero; control register needs sector 1.
// - write end sets irq flag and multi-function flag.
// - irq asserted only with all enables set and stack not full.
// - service clears only multi-function flag; irq flag stays.
// - control bits: write enable 3, write start 2, read enable 1, start 0.
// - array is 32 bytes of 8 bits, 5-bit address.
`timescale 1ns/1ps
`default_nettype none
module nvac_ctrl #(
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES,
  parameter int DEPTH        = 32,
  parameter int AW           = 5
) (
  input  wire  logic       clk,
  input  wire  logic       rstn,
  input  wire  logic [7:0] addr,
  input  wire  logic [7:0] wdata,
  input  wire  logic       wr_stb,
  input  wire  logic       rd_stb,
  input  wire  logic       stack_full,
  input  wire  logic       irq_ack,
  output var   logic [7:0] rdata,
  output var   logic       irq_req,
  output var   logic       busy
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  typedef enum logic [1:0] {IDLE, READING, WRITING} nvac_state_e;
  nvac_state_e   state;
  logic [AW-1:0] nv_address_reg;
  logic [7:0]    nv_data_reg;
  logic [7:0]    pointer_low_byte;
  logic [7:0]    pointer_high_byte;
  logic          write_enable_bit;
  logic          write_start_bit;
  logic          read_enable_bit;
  logic          read_start_bit;
  logic          nv_irq_flag;
  logic          nv_irq_enable;
  logic          mf_irq_flag;
  logic          mf_irq_enable;
  logic          global_irq_enable;
  logic [31:0]   count;
  logic [7:0]    mem [DEPTH];

  logic ctrl_sel;
  logic ctrl_wr;
  logic rd_go;
  logic wr_go;
  logic rd_done;
  logic wr_done;
  logic [7:0] ctrl_value;
  logic [7:0] irq_value;
  logic [7:0] next_rdata;
  logic       irq_wr;
  logic       write_tick;

  // width of the write timer divider
  localparam int TICK_W = $clog2(nvac_pkg::TICK_DIV);
  logic [TICK_W-1:0] tick_count;

  // control only visible when pointer selects sector 1, offset 40h
  // sector gating
  assign ctrl_sel = (pointer_low_byte == nvac_pkg::CTRL_PTR_LOW) &&
                    (pointer_high_byte == nvac_pkg::CTRL_PTR_HIGH);
  assign ctrl_wr  = wr_stb && (addr == nvac_pkg::ADDR_INDIRECT) && ctrl_sel;

  assign rd_go = ctrl_wr && (state == IDLE) && read_enable_bit &&
                 wdata[nvac_pkg::BIT_READ_START];
  // write start needs prior write enable
  assign wr_go = ctrl_wr && (state == IDLE) && write_enable_bit &&
                 wdata[nvac_pkg::BIT_WRITE_START] && !rd_go;

  assign rd_done = (state == READING) &&
                   (count == 32'(nvac_pkg::READ_CYCLES - 1));
  // write ends on timer tick
  // the tick runs free of the write, so the length varies by up to one tick
  assign wr_done = (state == WRITING) && write_tick &&
                   (count >= 32'(WRITE_CYCLES - 1));
  assign irq_wr  = wr_stb && (addr == nvac_pkg::ADDR_IRQ_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // sfr writes

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_address_reg    <= '0;
      pointer_low_byte  <= nvac_pkg::RST_BYTE;
      pointer_high_byte <= nvac_pkg::RST_BYTE;
    end else if (wr_stb) begin
      if (addr == nvac_pkg::ADDR_NV_ADDRESS) begin
        nv_address_reg <= wdata[AW-1:0];
      end else if (addr == nvac_pkg::ADDR_PTR_LOW) begin
        pointer_low_byte <= wdata;
      end else if (addr == nvac_pkg::ADDR_PTR_HIGH) begin
        pointer_high_byte <= wdata;
      end
    end
  end

  // data changes only on cpu write or read completion
  // fetched byte loads at read end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_data_reg <= nvac_pkg::RST_BYTE;
    end else if (rd_done) begin
      nv_data_reg <= mem[nv_address_reg];
    end else if (wr_stb && addr == nvac_pkg::ADDR_NV_DATA &&
                 state != WRITING) begin
      nv_data_reg <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_enable_bit <= 1'b0;
      read_enable_bit  <= 1'b0;
    end else if (ctrl_wr) begin
      write_enable_bit <= wdata[nvac_pkg::BIT_WRITE_ENABLE];
      read_enable_bit  <= wdata[nvac_pkg::BIT_READ_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_start_bit <= 1'b0;
    end else if (rd_go) begin
      read_start_bit <= 1'b1;
    end else if (rd_done) begin
      read_start_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_start_bit <= 1'b0;
    end else if (wr_go) begin
      write_start_bit <= 1'b1;
    end else if (wr_done) begin
      write_start_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write timer

  // free-running enable pulse; stands in for a timer that is not tied to
  // the cpu clock, so software must poll rather than count cycles
  // write timer tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_count <= '0;
    end else if (write_tick) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + TICK_W'(1);
    end
  end

  assign write_tick = (tick_count == TICK_W'(nvac_pkg::TICK_DIV - 1));

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer and storage

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= IDLE;
      count <= '0;
    end else begin
      case (state)
        IDLE: begin
          count <= '0;
          if (rd_go) begin
            state <= READING;
          end else if (wr_go) begin
            state <= WRITING;
          end
        end
        READING: begin
          count <= count + 32'd1;
          if (rd_done) begin
            state <= IDLE;
          end
        end
        WRITING: begin
          count <= count + 32'd1;
          if (wr_done) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // 32x8 array, commit at write end
  always_ff @(posedge clk) begin
    if (wr_done) begin
      mem[nv_address_reg] <= nv_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags

  // write end sets flag
  // set wins over a software clear in the same cycle, so no end is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_irq_flag <= 1'b0;
    end else if (wr_done) begin
      nv_irq_flag <= 1'b1;
    end else if (irq_wr) begin
      nv_irq_flag <= wdata[nvac_pkg::BIT_IRQ_FLAG];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mf_irq_flag <= 1'b0;
    end else if (wr_done) begin
      mf_irq_flag <= 1'b1;
    end else if (irq_wr) begin
      mf_irq_flag <= wdata[nvac_pkg::BIT_MF_FLAG];
    end else if (irq_ack) begin
      mf_irq_flag <= 1'b0;
    end
  end

  // interrupt enables, software only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_irq_enable     <= 1'b0;
      mf_irq_enable     <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (irq_wr) begin
      nv_irq_enable     <= wdata[nvac_pkg::BIT_IRQ_ENABLE];
      mf_irq_enable     <= wdata[nvac_pkg::BIT_MF_ENABLE];
      global_irq_enable <= wdata[nvac_pkg::BIT_GLOBAL_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= nv_irq_flag && nv_irq_enable && mf_irq_flag &&
                 mf_irq_enable && global_irq_enable && !stack_full;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != IDLE) || rd_go || wr_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  assign ctrl_value = {4'h0, write_enable_bit, write_start_bit,
                       read_enable_bit, read_start_bit};
  assign irq_value  = {3'h0, global_irq_enable, mf_irq_enable, mf_irq_flag,
                       nv_irq_enable, nv_irq_flag};

  always_comb begin
    next_rdata = 8'h00;
    if (addr == nvac_pkg::ADDR_NV_ADDRESS) begin
      next_rdata = {{(8-AW){1'b0}}, nv_address_reg};
    end else if (addr == nvac_pkg::ADDR_NV_DATA) begin
      next_rdata = nv_data_reg;
    end else if (addr == nvac_pkg::ADDR_PTR_LOW) begin
      next_rdata = pointer_low_byte;
    end else if (addr == nvac_pkg::ADDR_PTR_HIGH) begin
      next_rdata = pointer_high_byte;
    end else if (addr == nvac_pkg::ADDR_INDIRECT && ctrl_sel) begin
      next_rdata = ctrl_value;
    end else if (addr == nvac_pkg::ADDR_IRQ_CTRL) begin
      next_rdata = irq_value;
    end
  end

  // unmapped or unselected reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // nvac_ctrl
`default_nettype wire

// ---- nvac_ctrl_monitor.sv ----
/* nvac_ctrl_monitor: port assertions for nvac_ctrl.
   assumes the bind below and a single cpu bus master. */
`timescale 1ns/1ps
`default_nettype none
module nvac_ctrl_monitor #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic       stack_full,
  input wire logic       irq_ack,
  input wire logic [7:0] rdata,
  input wire logic       irq_req,
  input wire logic       busy
);
  // timer length, up to one write tick more, and the registered end edge
  localparam int WMAX = WRITE_CYCLES + nvac_pkg::TICK_DIV + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_quiet; !rd_stb |=> rdata == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data not zero outside a read");
  property p_por; $rose(rstn) |-> !busy && !irq_req; endproperty
  a_por: assert property (p_por)
    else $error("busy or irq after reset");
  property p_wr_len; $rose(busy) |-> ##[1:WMAX] !busy; endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("cycle runs too long");
  property p_rd_len; $rose(busy) && $past(wdata[0]) |-> ##[1:4] !busy;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read cycle runs too long");
  property p_src;
    $rose(busy) |-> $past(wr_stb) && $past(addr) == 8'h04;
  endproperty
  a_src: assert property (p_src)
    else $error("cycle started without control write");
  property p_bits;
    $rose(busy) |-> ($past(wdata[2]) && $past(wdata[3]))
      || ($past(wdata[0]) && $past(wdata[1]));
  endproperty
  a_bits: assert property (p_bits)
    else $error("cycle started without start and enable");
  property p_stack; stack_full |=> !irq_req; endproperty
  a_stack: assert property (p_stack)
    else $error("irq raised with stack full");
  property p_ack; irq_ack |-> ##2 !irq_req; endproperty
  a_ack: assert property (p_ack)
    else $error("irq still raised after service");
  c_write: cover property ($rose(busy) && $past(wdata[2]));
  c_irq: cover property ($rose(irq_req));
  c_ack: cover property (irq_ack && !stack_full);
endmodule // nvac_ctrl_monitor
bind nvac_ctrl nvac_ctrl_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .stack_full(stack_full), .irq_ack(irq_ack),
  .rdata(rdata), .irq_req(irq_req), .busy(busy));
`default_nettype wire

// ---- nvac_cpu.sv ----
/* nvac_cpu: cpu core model, bus master and irq service.
   assumes tasks are called from the bench, one bus cycle per call. */
`timescale 1ns/1ps
`default_nettype none
module nvac_cpu (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       irq_req,
  input  wire logic       stack_full,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr_stb,
  output var  logic       rd_stb,
  output var  logic       irq_ack
);
  logic [7:0] rd_q;
  logic       ack_q;
  initial begin
    {addr, wdata, wr_stb, rd_stb, irq_ack} = '0;
  end
  // sampled at the edge, so no race with the next read strobe
  always @(posedge clk) rd_q <= rdata;
  // vector taken only with room on the stack
  // the model never sleeps, so no access is cut short
  // the request drops two cycles after service, so hold off one more
  always @(posedge clk) ack_q <= irq_ack;
  always @(posedge clk) begin
    irq_ack <= irq_req && !stack_full && !irq_ack && !ack_q;
  end
  // software drives one strobe per cycle
  task automatic bus(input logic w, r, input logic [7:0] a, dt);
    @(posedge clk);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= dt;
  endtask
  task automatic wr(input logic [7:0] a, dt);
    bus(1'b1, 1'b0, a, dt);
  endtask
  // polling and read back go through here
  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge clk);
    #1 dt = rd_q;
  endtask
endmodule // nvac_cpu
`default_nettype wire

// ---- nvac_ctrl_bench.sv ----
/* nvac_ctrl_bench: scenario tests of nvac_ctrl.
   assumes nvac_cpu as the bus master and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module nvac_ctrl_bench;
  logic       clk, rstn, stack_full;
  logic [7:0] addr, wdata, rdata, d;
  logic       wr_stb, rd_stb, irq_ack, irq_req, busy;
  int         n_mismatch = 0;
  int         total_checks = 0;
  nvac_ctrl #(.WRITE_CYCLES(20)) dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .stack_full(stack_full), .irq_ack(irq_ack), .rdata(rdata),
    .irq_req(irq_req), .busy(busy));
  nvac_cpu cpu (.clk(clk), .rdata(rdata), .irq_req(irq_req),
    .stack_full(stack_full), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .irq_ack(irq_ack));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, e, input string m);
    cpu.rd(a, d);
    chk(d, e, m);
  endtask
  // a slow write must still end, the bound only catches a hang
  task automatic poll(input int b);
    cpu.rd(8'h04, d);
    for (int i = 0; i < 400 && d[b] !== 1'b0; i++) cpu.rd(8'h04, d);
    chk({7'h00, d[b]}, 8'h00, "start bit stuck");
  endtask
  task automatic t_por;
    rc(8'h05, 8'h00, "irq ctrl after reset");
    rc(8'h00, 8'h00, "address after reset");
    rc(8'h04, 8'h00, "control seen in sector 0");
    cpu.wr(8'h04, 8'h0C);
    rc(8'h04, 8'h00, "control written in sector 0");
    chk({7'h00, busy}, 8'h00, "busy without pointer");
    $display("t_por done");
  endtask
  task automatic t_write;
    cpu.wr(8'h00, 8'h3F);
    cpu.wr(8'h01, 8'hA5);
    cpu.wr(8'h05, 8'h00);
    cpu.wr(8'h02, 8'h40);
    cpu.wr(8'h03, 8'h01);
    cpu.wr(8'h04, 8'h08);
    cpu.wr(8'h04, 8'h0C);
    rc(8'h04, 8'h0C, "write not running");
    poll(2);
    rc(8'h05, 8'h05, "write end flags");
    chk({7'h00, irq_req}, 8'h00, "irq while disabled");
    rc(8'h00, 8'h1F, "address width");
    $display("t_write done");
  endtask
  task automatic t_read;
    cpu.wr(8'h01, 8'h00);
    cpu.wr(8'h04, 8'h02);
    cpu.wr(8'h04, 8'h03);
    poll(0);
    rc(8'h01, 8'hA5, "read data");
    cpu.wr(8'h00, 8'h00);
    rc(8'h01, 8'hA5, "data not held");
    $display("t_read done");
  endtask
  task automatic t_refuse;
    cpu.wr(8'h04, 8'h00);
    cpu.wr(8'h04, 8'h04);
    rc(8'h04, 8'h00, "write start taken");
    cpu.wr(8'h04, 8'h01);
    rc(8'h04, 8'h00, "read start taken");
    chk({7'h00, busy}, 8'h00, "busy on refused start");
    rc(8'h01, 8'hA5, "data lost");
    $display("t_refuse done");
  endtask
  task automatic t_irq;
    @(posedge clk) stack_full <= 1'b1;
    cpu.wr(8'h05, 8'h0A);
    cpu.wr(8'h04, 8'h08);
    cpu.wr(8'h04, 8'h0C);
    cpu.wr(8'h04, 8'h0B);
    cpu.wr(8'h05, 8'h1A);
    rc(8'h04, 8'h0E, "start bits changed while busy");
    poll(2);
    rc(8'h04, 8'h0A, "read ran during write");
    chk({7'h00, irq_req}, 8'h00, "irq with stack full");
    @(posedge clk) stack_full <= 1'b0;
    for (int i = 0; i < 10 && irq_ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, irq_ack}, 8'h01, "irq not serviced");
    rc(8'h05, 8'h1B, "flags after service");
    cpu.wr(8'h05, 8'h1A);
    rc(8'h05, 8'h1A, "flag not cleared");
    chk({7'h00, irq_req}, 8'h00, "irq after clear");
    $display("t_irq done");
  endtask
  // a reset in mid-run must clear write enable and the pointer again
  task automatic t_reset;
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rc(8'h03, 8'h00, "pointer high after reset");
    cpu.wr(8'h02, 8'h40);
    cpu.wr(8'h03, 8'h01);
    rc(8'h04, 8'h00, "write enable after reset");
    cpu.wr(8'h04, 8'h04);
    rc(8'h04, 8'h00, "write taken after reset");
    cpu.wr(8'h04, 8'h08);
    cpu.wr(8'h03, 8'h00);
    cpu.wr(8'h04, 8'h0C);
    cpu.wr(8'h03, 8'h01);
    rc(8'h04, 8'h08, "control reached in sector 0");
    chk({7'h00, busy}, 8'h00, "write from sector 0");
    cpu.wr(8'h04, 8'h00);
    rc(8'h04, 8'h00, "enable not cleared");
    $display("t_reset done");
  endtask
  initial begin
    rstn = 0;
    stack_full = 0;
    d = 8'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_por;
    t_write;
    t_read;
    t_refuse;
    t_irq;
    t_reset;
    stop_test;
  end
  initial begin
    #500us;
    n_mismatch++;
    stop_test;
  end
endmodule // nvac_ctrl_bench
`default_nettype wire
